//--- core/wrr_ctrl.sv
// Wakeup control, retention latch and reset reason bookkeeping
//
// Behaviour
// - Polarity bit one makes the selectable pin subset wake on low level.
// - Latch bit zero passes pin setup through; one holds the captured setup.
// - Watchdog reset on deep sleep; with enable bit also on retention modes.
// - All four reset sources start the same reset sequence.
// - Reset reason reads zero after an internal generator reset.
// - Any write to reset reason clears all its bits, except bits of sources active in the same cycle.
// - Reset reason bits accumulate until a write or generator reset.
// - Reason bit 0 pin, bit 1 watchdog, bit 2 debugger; rest zero.
// - Source codes: 00 conditional, 10 always, 11 ignore, in standby.
// - Wake config bits 7:6 govern radio interrupt, enable bit one.
// - Wake config bits 5:4 govern tick, enable bit five.
// - Wake config bits 3:2 govern pin wakeup interrupt, enable bit three.
// - Wake config bits 1:0 govern miscellaneous interrupt, enable bit four.
// - Miscellaneous interrupt on oscillator ready, conversion done, new random.
// - Each pin enable bit set allows wakeup from its pin.
// - Pin enable bits unused in the package variant have no effect.
// - Pins outside the selectable subset always wake on high level.
// - Enabled slave chip select low acts as an extra pin wakeup.
// - Pin wakeup sets a flag cleared by read or power-down entry.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "wrr_regs.svh"

module wrr_ctrl (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire wrr_pkg::wrr_bus_t bus_in,
   output logic [7:0] rdata_out,
   input wire wrr_pkg::wrr_variant_t variant_in,
   input wire wrr_pkg::wrr_rst_src_t rst_src_in,
   output logic sys_reset_out,
   input wire wrr_pkg::wrr_irq_src_t irq_src_in,
   input wire logic [7:0] interrupt_enable_one_in,
   input wire logic standby_in,
   input wire logic [15:0] wake_pins_in,
   input wire logic spi_slave_en_in,
   input wire logic slave_chip_select_n_in,
   input wire logic enter_pd_in,
   input wire logic [2:0] pd_mode_in,
   input wire logic pin_flag_rd_in,
   input wire logic [15:0] pin_setup_in,
   output logic [15:0] pin_setup_out,
   output logic miscellaneous_interrupt_out,
   output logic pin_wakeup_interrupt_out,
   output logic wake_out,
   output logic pin_wake_flag_out,
   output logic wdt_reset_out
);
   import wrr_pkg::*;

   localparam logic [3:0] STARTUP_CYC = 4'(`WRR_STARTUP_CYC);

   wrr_state_t s;
   wrr_state_t next_s;
   logic [15:0] used_mask;
   logic [15:0] pol_mask;
   logic [15:0] pin_en;
   logic [15:0] pin_hit;
   logic any_rst;
   logic rsn_wr;

   // ----------------------------------------
   // Source gating
   // ----------------------------------------
   // decode of one two-bit source field
   function automatic logic src_allow(input logic [1:0] code, input logic ien);
      logic res;
      res = 1'b0;
      case (code)
         `WRR_SRC_COND: res = ien;
         `WRR_SRC_ALWAYS: res = 1'b1;
         default: res = 1'b0;
      endcase
      return res;
   endfunction

   always_comb begin
      case (variant_in)
         WRR_PKG_LARGE: begin
            used_mask = `WRR_USED_LARGE;
            pol_mask = `WRR_POL_LARGE;
         end
         WRR_PKG_MID: begin
            used_mask = `WRR_USED_MID;
            pol_mask = `WRR_POL_MID;
         end
         WRR_PKG_SMALL: begin
            used_mask = `WRR_USED_SMALL;
            pol_mask = `WRR_POL_SMALL;
         end
         default: begin
            used_mask = `WRR_RST_VAL_16;
            pol_mask = `WRR_RST_VAL_16;
         end
      endcase
   end

   assign pin_en = {s.pin_en_hi, s.pin_en_lo};

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_pin
         // selectable pins invert when polarity bit set
         assign pin_hit[gi] = pin_en[gi] & used_mask[gi] &
            (wake_pins_in[gi] ^ (s.opm[`WRR_OPM_POL_BIT] & pol_mask[gi]));
      end
   endgenerate

   assign any_rst = rst_src_in.pin | rst_src_in.watchdog | rst_src_in.debugger;
   assign rsn_wr = bus_in.wr && (bus_in.addr == `WRR_ADDR_RST_REASON);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_s = s;

      // Register writes
      if (bus_in.wr) begin
         case (bus_in.addr)
            `WRR_ADDR_WAKE_CFG: next_s.wake_cfg = bus_in.wdata;
            `WRR_ADDR_OPM_CTRL: next_s.opm = bus_in.wdata[2:0];
            `WRR_ADDR_PIN_EN_HI: next_s.pin_en_hi = bus_in.wdata;
            `WRR_ADDR_PIN_EN_LO: next_s.pin_en_lo = bus_in.wdata;
            default: next_s.opm = s.opm;
         endcase
      end

      if (rsn_wr) begin
         next_s.rsn = 3'h0;
      end
      // new sources OR in, set wins over clear
      if (any_rst) begin
         next_s.rsn = (rsn_wr ? 3'h0 : s.rsn) |
            {rst_src_in.debugger, rst_src_in.watchdog, rst_src_in.pin};
      end

      // Register reads, data in next cycle
      next_s.rdata = `WRR_RST_VAL_8;
      if (bus_in.rd) begin
         case (bus_in.addr)
            `WRR_ADDR_WAKE_CFG: next_s.rdata = s.wake_cfg;
            `WRR_ADDR_OPM_CTRL: next_s.rdata = {5'h00, s.opm};
            `WRR_ADDR_RST_REASON: next_s.rdata = {5'h00, s.rsn};
            `WRR_ADDR_PIN_EN_HI: next_s.rdata = s.pin_en_hi;
            `WRR_ADDR_PIN_EN_LO: next_s.rdata = s.pin_en_lo;
            default: next_s.rdata = `WRR_RST_VAL_8;
         endcase
      end

      case (s.seq)
         WRR_RUN: begin
            next_s.sys_reset = 1'b0;
            if (any_rst) begin
               next_s.seq = WRR_RESET_SEQ;
               next_s.seq_cnt = 4'h0;
               next_s.sys_reset = 1'b1;
            end
         end
         WRR_RESET_SEQ: begin
            next_s.sys_reset = 1'b1;
            if (any_rst) begin
               next_s.seq_cnt = 4'h0;
            end else if (s.seq_cnt == STARTUP_CYC - 4'h1) begin
               next_s.seq = WRR_RUN;
               next_s.sys_reset = 1'b0;
            end else begin
               next_s.seq_cnt = s.seq_cnt + 4'h1;
            end
         end
         default: next_s.seq = WRR_RUN;
      endcase

      if (!s.opm[`WRR_OPM_LATCH_BIT]) begin
         next_s.latched = pin_setup_in;
      end

      next_s.misc_irq = irq_src_in.xosc_ready | irq_src_in.adc_done | irq_src_in.rng_ready;
      // slave chip select as pin source
      next_s.pin_irq = (|pin_hit) | (spi_slave_en_in & ~slave_chip_select_n_in);

      next_s.wake = standby_in & (
         (irq_src_in.radio_interrupt &
            src_allow(s.wake_cfg[7:6], interrupt_enable_one_in[`WRR_IEN_RADIO_BIT])) |
         (irq_src_in.tick &
            src_allow(s.wake_cfg[5:4], interrupt_enable_one_in[`WRR_IEN_TICK_BIT])) |
         (next_s.pin_irq &
            src_allow(s.wake_cfg[3:2], interrupt_enable_one_in[`WRR_IEN_PIN_BIT])) |
         (next_s.misc_irq &
            src_allow(s.wake_cfg[1:0], interrupt_enable_one_in[`WRR_IEN_MISC_BIT])));

      // pin wake flag, set wins over clear
      if (pin_flag_rd_in || enter_pd_in) begin
         next_s.pin_flag = 1'b0;
      end
      if (standby_in && next_s.pin_irq &&
         src_allow(s.wake_cfg[3:2], interrupt_enable_one_in[`WRR_IEN_PIN_BIT])) begin
         next_s.pin_flag = 1'b1;
      end

      next_s.wdt_reset = enter_pd_in && ((pd_mode_in == `WRR_PD_DEEP) ||
         (s.opm[`WRR_OPM_WDT_BIT] && ((pd_mode_in == `WRR_PD_MEM_OFF) ||
         (pd_mode_in == `WRR_PD_MEM_ON) || (pd_mode_in == `WRR_PD_REG_RET))));
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // generator reset clears reason and starts sequence
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= '0;
         s.seq <= WRR_RESET_SEQ;
         s.sys_reset <= 1'b1;
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   assign rdata_out = s.rdata;
   assign sys_reset_out = s.sys_reset;
   assign pin_setup_out = s.latched;
   assign miscellaneous_interrupt_out = s.misc_irq;
   assign pin_wakeup_interrupt_out = s.pin_irq;
   assign wake_out = s.wake;
   assign pin_wake_flag_out = s.pin_flag;
   assign wdt_reset_out = s.wdt_reset;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   property p_rsn_clear;
      ce_in && rsn_wr && !any_rst |=> s.rsn == 3'h0;
   endproperty
   a_rsn_clear: assert property (p_rsn_clear) else $error("reason not cleared");

   property p_rsn_accum;
      ce_in && rst_src_in.watchdog && !rsn_wr |=> s.rsn == ($past(s.rsn) | 3'h2 |
         $past({rst_src_in.debugger, 1'b0, rst_src_in.pin}));
   endproperty
   a_rsn_accum: assert property (p_rsn_accum) else $error("reason not accumulated");

   property p_rsn_map;
      ce_in && rst_src_in.debugger |=> s.rsn[`WRR_RSN_DBG_BIT];
   endproperty
   a_rsn_map: assert property (p_rsn_map) else $error("debugger bit missing");

   property p_rsn_hold;
      ce_in && !any_rst && !rsn_wr |=> $stable(s.rsn);
   endproperty
   a_rsn_hold: assert property (p_rsn_hold) else $error("reason changed");

   property p_seq;
      ce_in && any_rst |=> sys_reset_out;
   endproperty
   a_seq: assert property (p_seq) else $error("reset sequence not started");

   property p_latch_pass;
      ce_in && !s.opm[`WRR_OPM_LATCH_BIT] |=> pin_setup_out == $past(pin_setup_in);
   endproperty
   a_latch_pass: assert property (p_latch_pass) else $error("latch not passing");

   property p_latch_hold;
      ce_in && s.opm[`WRR_OPM_LATCH_BIT] |=> $stable(pin_setup_out);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch not holding");

   property p_wdt;
      ce_in && enter_pd_in && !s.opm[`WRR_OPM_WDT_BIT] && pd_mode_in == `WRR_PD_REG_RET
         |=> !wdt_reset_out;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog reset without enable");

   property p_misc;
      ce_in && irq_src_in.rng_ready |=> miscellaneous_interrupt_out;
   endproperty
   a_misc: assert property (p_misc) else $error("misc interrupt missing");

   property p_spi;
      ce_in && standby_in && spi_slave_en_in && !slave_chip_select_n_in &&
         s.wake_cfg[3:2] == `WRR_SRC_ALWAYS |=> wake_out && pin_wakeup_interrupt_out;
   endproperty
   a_spi: assert property (p_spi) else $error("chip select wake missing");

   property p_ignore;
      ce_in && s.wake_cfg == 8'hff |=> !wake_out;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored source woke");

   property p_rsvd;
      ce_in && s.wake_cfg == 8'hf7 |=> !wake_out;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved code woke");

   property p_flag;
      ce_in && pin_flag_rd_in && !next_s.pin_irq |=> !pin_wake_flag_out;
   endproperty
   a_flag: assert property (p_flag) else $error("pin flag not cleared");

   property p_flag_set;
      ce_in && standby_in && spi_slave_en_in && !slave_chip_select_n_in &&
         s.wake_cfg[3:2] == `WRR_SRC_ALWAYS |=> pin_wake_flag_out;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("pin flag not set");

   property p_rsn_pin;
      ce_in && rst_src_in.pin |=> s.rsn[`WRR_RSN_PIN_BIT];
   endproperty
   a_rsn_pin: assert property (p_rsn_pin) else $error("pin reason bit missing");

   property p_seq_end;
      ce_in && !any_rst && s.seq == WRR_RESET_SEQ && s.seq_cnt == STARTUP_CYC - 4'h1
         |=> !sys_reset_out;
   endproperty
   a_seq_end: assert property (p_seq_end) else $error("reset sequence overran");

   property p_wdt_deep;
      ce_in && enter_pd_in && pd_mode_in == `WRR_PD_DEEP |=> wdt_reset_out;
   endproperty
   a_wdt_deep: assert property (p_wdt_deep) else $error("no watchdog reset on deep sleep");

   property p_pin_high;
      ce_in && (wake_pins_in & ~pol_mask & used_mask & pin_en) != 16'h0000
         |=> pin_wakeup_interrupt_out;
   endproperty
   a_pin_high: assert property (p_pin_high) else $error("high pin did not wake");

   property p_unused;
      ce_in && !spi_slave_en_in && !s.opm[`WRR_OPM_POL_BIT] &&
         (wake_pins_in & used_mask) == 16'h0000 |=> !pin_wakeup_interrupt_out;
   endproperty
   a_unused: assert property (p_unused) else $error("unused pin raised interrupt");

   property p_radio_cond;
      ce_in && standby_in && irq_src_in.radio_interrupt &&
         s.wake_cfg[7:6] == `WRR_SRC_COND &&
         interrupt_enable_one_in[`WRR_IEN_RADIO_BIT] |=> wake_out;
   endproperty
   a_radio_cond: assert property (p_radio_cond) else $error("radio did not wake");

   property p_tick_cond;
      ce_in && standby_in && irq_src_in.tick &&
         s.wake_cfg[5:4] == `WRR_SRC_COND &&
         interrupt_enable_one_in[`WRR_IEN_TICK_BIT] |=> wake_out;
   endproperty
   a_tick_cond: assert property (p_tick_cond) else $error("tick did not wake");

   property p_misc_cond;
      ce_in && standby_in && irq_src_in.xosc_ready &&
         s.wake_cfg[1:0] == `WRR_SRC_COND &&
         interrupt_enable_one_in[`WRR_IEN_MISC_BIT] |=> wake_out;
   endproperty
   a_misc_cond: assert property (p_misc_cond) else $error("misc source did not wake");

   property p_asleep;
      ce_in && !standby_in |=> !wake_out;
   endproperty
   a_asleep: assert property (p_asleep) else $error("wake outside standby");

   c_seq: cover property (ce_in && any_rst ##1 sys_reset_out [*3] ##1 !sys_reset_out);
   c_accum: cover property (s.rsn == 3'h6);
   c_pin_wake: cover property (ce_in && wake_out && pin_wake_flag_out);
   c_wdt: cover property (wdt_reset_out);
   c_flag_clear: cover property (pin_wake_flag_out ##1 !pin_wake_flag_out);

endmodule

//--- core/wrr_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WRR_REGS_SVH
`define WRR_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WRR_ADDR_WAKE_CFG 8'ha5
`define WRR_ADDR_OPM_CTRL 8'hae
`define WRR_ADDR_RST_REASON 8'hb1
`define WRR_ADDR_PIN_EN_HI 8'hce
`define WRR_ADDR_PIN_EN_LO 8'hcf

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define WRR_OPM_POL_BIT 2
`define WRR_OPM_LATCH_BIT 1
`define WRR_OPM_WDT_BIT 0
`define WRR_RSN_PIN_BIT 0
`define WRR_RSN_WDT_BIT 1
`define WRR_RSN_DBG_BIT 2
`define WRR_RST_VAL_8 8'h00
`define WRR_RST_VAL_16 16'h0000
`define WRR_SRC_COND 2'h0
`define WRR_SRC_RSVD 2'h1
`define WRR_SRC_ALWAYS 2'h2
`define WRR_SRC_IGNORE 2'h3
`define WRR_IEN_RADIO_BIT 1
`define WRR_IEN_PIN_BIT 3
`define WRR_IEN_MISC_BIT 4
`define WRR_IEN_TICK_BIT 5

// ----------------------------------------
// Power-down mode codes
// ----------------------------------------
`define WRR_PD_DEEP 3'h1
`define WRR_PD_MEM_OFF 3'h2
`define WRR_PD_MEM_ON 3'h3
`define WRR_PD_REG_RET 3'h4

// ----------------------------------------
// Pin masks per package variant
// ----------------------------------------
`define WRR_USED_LARGE 16'hffff
`define WRR_USED_MID 16'h7fff
`define WRR_USED_SMALL 16'h007f
`define WRR_POL_LARGE 16'h0044
`define WRR_POL_MID 16'h1440
`define WRR_POL_SMALL 16'h0040

// ----------------------------------------
// Timing
// ----------------------------------------
`define WRR_CLK_NS 10
`define WRR_STARTUP_NS 100
`define WRR_STARTUP_CYC ((`WRR_STARTUP_NS + `WRR_CLK_NS - 1) / `WRR_CLK_NS)

`endif

//--- core/wrr_pkg.sv
// Types shared by the wakeup and reset reason block
package wrr_pkg;

   typedef enum logic [1:0] {
      WRR_PKG_LARGE,
      WRR_PKG_MID,
      WRR_PKG_SMALL
   } wrr_variant_t;

   typedef enum logic {
      WRR_RUN,
      WRR_RESET_SEQ
   } wrr_seq_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wrr_bus_t;

   typedef struct packed {
      logic pin;
      logic watchdog;
      logic debugger;
   } wrr_rst_src_t;

   typedef struct packed {
      logic radio_interrupt;
      logic tick;
      logic xosc_ready;
      logic adc_done;
      logic rng_ready;
   } wrr_irq_src_t;

   typedef struct packed {
      wrr_seq_t seq;
      logic [3:0] seq_cnt;
      logic sys_reset;
      logic [2:0] opm;
      logic [7:0] wake_cfg;
      logic [7:0] pin_en_hi;
      logic [7:0] pin_en_lo;
      logic [2:0] rsn;
      logic [7:0] rdata;
      logic [15:0] latched;
      logic misc_irq;
      logic pin_irq;
      logic wake;
      logic pin_flag;
      logic wdt_reset;
   } wrr_state_t;

endpackage

//--- testbench/wrr_pin_model.sv
// External wakeup pins and slave chip select seen by the block
`timescale 1ns/1ps

module wrr_pin_model (
   input wire logic mclk_in,
   input wire logic [15:0] level_in,
   input wire logic csn_in,
   output logic [15:0] wake_pins_out,
   output logic slave_chip_select_n_out
);
   // Pins settle one cycle after the bench asks
   always_ff @(posedge mclk_in) begin
      wake_pins_out <= level_in;
      slave_chip_select_n_out <= csn_in;
   end
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the wakeup and reset reason block
`timescale 1ns/1ps
`include "wrr_regs.svh"

module tb_top;
   import wrr_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   wrr_bus_t bus = '0;
   wrr_variant_t var_s = WRR_PKG_LARGE;
   wrr_rst_src_t rsrc = '0;
   wrr_irq_src_t irq = '0;
   logic [7:0] ien = 8'h00;
   logic [7:0] rdata;
   logic ce = 1'b1;
   logic standby = 1'b0, spi_en = 1'b0, csn = 1'b1, enter_pd = 1'b0, flag_rd = 1'b0;
   logic [2:0] pd_mode = 3'h0;
   logic [15:0] lvl = 16'h0000, setup_in = 16'h0000, pins, setup_out;
   logic csn_pin, sys_rst, misc, pirq, wake, flag, wdt;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;

   wrr_pin_model pins_m (.mclk_in(mclk_in), .level_in(lvl), .csn_in(csn),
      .wake_pins_out(pins), .slave_chip_select_n_out(csn_pin));

   wrr_ctrl uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce), .bus_in(bus),
      .rdata_out(rdata), .variant_in(var_s), .rst_src_in(rsrc), .sys_reset_out(sys_rst),
      .irq_src_in(irq), .interrupt_enable_one_in(ien), .standby_in(standby),
      .wake_pins_in(pins), .spi_slave_en_in(spi_en), .slave_chip_select_n_in(csn_pin),
      .enter_pd_in(enter_pd), .pd_mode_in(pd_mode), .pin_flag_rd_in(flag_rd),
      .pin_setup_in(setup_in), .pin_setup_out(setup_out),
      .miscellaneous_interrupt_out(misc), .pin_wakeup_interrupt_out(pirq),
      .wake_out(wake), .pin_wake_flag_out(flag), .wdt_reset_out(wdt));

   // ----------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end

   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_in);
      bus.wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_in);
      bus.rd <= 1'b0;
      #1 chk("rdata", {8'h00, exp}, {8'h00, rdata});
   endtask

   task automatic gen_reset();
      @(posedge mclk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
   endtask

   task automatic src_pulse(input wrr_rst_src_t v);
      @(posedge mclk_in);
      rsrc <= v;
      @(posedge mclk_in);
      rsrc <= '0;
      #1;
   endtask

   task automatic wake_case(input logic [7:0] cfg, input logic [7:0] ie,
      input logic [4:0] iv, input logic [15:0] lv, input logic exp);
      wr(`WRR_ADDR_WAKE_CFG, cfg);
      @(posedge mclk_in);
      ien <= ie;
      irq <= iv;
      lvl <= lv;
      tick(3);
      chk("wake_out", {15'h0000, exp}, {15'h0000, wake});
      chk("misc_irq", {15'h0000, |iv[2:0]}, {15'h0000, misc});
   endtask

   task automatic pd(input logic [2:0] m, input logic exp);
      @(posedge mclk_in);
      enter_pd <= 1'b1;
      pd_mode <= m;
      @(posedge mclk_in);
      enter_pd <= 1'b0;
      #1 chk("wdt_reset", {15'h0000, exp}, {15'h0000, wdt});
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [7:0] a [5];
      a = '{`WRR_ADDR_WAKE_CFG, `WRR_ADDR_OPM_CTRL, `WRR_ADDR_RST_REASON,
         `WRR_ADDR_PIN_EN_HI, `WRR_ADDR_PIN_EN_LO};
      for (int i = 0; i < 5; i++) begin
         rd_chk(a[i], 8'h00);
      end
      rd_chk(8'ha6, 8'h00);
      wr(`WRR_ADDR_OPM_CTRL, 8'h07);
      rd_chk(`WRR_ADDR_OPM_CTRL, 8'h07);
      wr(`WRR_ADDR_PIN_EN_HI, 8'ha5);
      wr(`WRR_ADDR_PIN_EN_LO, 8'h3c);
      rd_chk(`WRR_ADDR_PIN_EN_HI, 8'ha5);
      rd_chk(`WRR_ADDR_PIN_EN_LO, 8'h3c);
      // Clock enable low freezes the registers
      @(posedge mclk_in);
      ce <= 1'b0;
      wr(`WRR_ADDR_PIN_EN_LO, 8'hff);
      @(posedge mclk_in);
      ce <= 1'b1;
      rd_chk(`WRR_ADDR_PIN_EN_LO, 8'h3c);
      wr(`WRR_ADDR_OPM_CTRL, 8'h00);
      $display("test regs done");
   endtask

   task automatic t_reason();
      src_pulse('{pin: 1'b0, watchdog: 1'b0, debugger: 1'b1});
      tick(12);
      src_pulse('{pin: 1'b0, watchdog: 1'b1, debugger: 1'b0});
      chk("sys_reset", 16'h0001, {15'h0000, sys_rst});
      tick(9);
      chk("sys_reset", 16'h0001, {15'h0000, sys_rst});
      tick(1);
      chk("sys_reset", 16'h0000, {15'h0000, sys_rst});
      rd_chk(`WRR_ADDR_RST_REASON, 8'h06);
      src_pulse('{pin: 1'b1, watchdog: 1'b0, debugger: 1'b0});
      rd_chk(`WRR_ADDR_RST_REASON, 8'h07);
      wr(`WRR_ADDR_RST_REASON, 8'hff);
      rd_chk(`WRR_ADDR_RST_REASON, 8'h00);
      src_pulse('{pin: 1'b0, watchdog: 1'b1, debugger: 1'b0});
      gen_reset();
      rd_chk(`WRR_ADDR_RST_REASON, 8'h00);
      $display("test reason done");
   endtask

   task automatic t_wake();
      wr(`WRR_ADDR_PIN_EN_LO, 8'h01);
      @(posedge mclk_in);
      standby <= 1'b1;
      wake_case(8'hf3, 8'h00, 5'h00, 16'h0001, 1'b0);
      wake_case(8'hf3, 8'h08, 5'h00, 16'h0001, 1'b1);
      wake_case(8'hf7, 8'hff, 5'h00, 16'h0001, 1'b0);
      wake_case(8'hfb, 8'h00, 5'h00, 16'h0001, 1'b1);
      wake_case(8'hff, 8'hff, 5'h00, 16'h0001, 1'b0);
      wake_case(8'hfb, 8'h00, 5'h00, 16'h0002, 1'b0);
      wake_case(8'h3f, 8'h02, 5'h10, 16'h0000, 1'b1);
      wake_case(8'h3f, 8'hfd, 5'h10, 16'h0000, 1'b0);
      wake_case(8'hcf, 8'h20, 5'h08, 16'h0000, 1'b1);
      wake_case(8'hfc, 8'h10, 5'h04, 16'h0000, 1'b1);
      wake_case(8'hfc, 8'hef, 5'h04, 16'h0000, 1'b0);
      wake_case(8'hfe, 8'h00, 5'h02, 16'h0000, 1'b1);
      wake_case(8'hfe, 8'h00, 5'h01, 16'h0000, 1'b1);
      @(posedge mclk_in);
      standby <= 1'b0;
      wake_case(8'hfb, 8'h00, 5'h00, 16'h0001, 1'b0);
      @(posedge mclk_in);
      standby <= 1'b1;
      $display("test wake done");
   endtask

   task automatic t_pins();
      wr(`WRR_ADDR_PIN_EN_HI, 8'hff);
      wr(`WRR_ADDR_PIN_EN_LO, 8'hff);
      wr(`WRR_ADDR_OPM_CTRL, 8'h04);
      wake_case(8'hfb, 8'h00, 5'h00, 16'h0044, 1'b0);
      chk("pin_irq", 16'h0000, {15'h0000, pirq});
      wake_case(8'hfb, 8'h00, 5'h00, 16'h0040, 1'b1);
      chk("pin_flag", 16'h0001, {15'h0000, flag});
      @(posedge mclk_in);
      lvl <= 16'h0044;
      tick(2);
      @(posedge mclk_in);
      flag_rd <= 1'b1;
      @(posedge mclk_in);
      flag_rd <= 1'b0;
      tick(2);
      chk("pin_flag", 16'h0000, {15'h0000, flag});
      wr(`WRR_ADDR_OPM_CTRL, 8'h00);
      wake_case(8'hfb, 8'h00, 5'h00, 16'h0000, 1'b0);
      @(posedge mclk_in);
      var_s <= WRR_PKG_SMALL;
      wake_case(8'hfb, 8'h00, 5'h00, 16'hff80, 1'b0);
      @(posedge mclk_in);
      spi_en <= 1'b1;
      csn <= 1'b0;
      wake_case(8'hfb, 8'h00, 5'h00, 16'h0000, 1'b1);
      chk("pin_irq", 16'h0001, {15'h0000, pirq});
      @(posedge mclk_in);
      spi_en <= 1'b0;
      wake_case(8'hfb, 8'h00, 5'h00, 16'h0000, 1'b0);
      $display("test pins done");
   endtask

   task automatic t_latch_wdt();
      @(posedge mclk_in);
      setup_in <= 16'h1234;
      tick(2);
      chk("pin_setup", 16'h1234, setup_out);
      wr(`WRR_ADDR_OPM_CTRL, 8'h02);
      @(posedge mclk_in);
      setup_in <= 16'h5aa5;
      tick(3);
      chk("pin_setup", 16'h1234, setup_out);
      @(posedge mclk_in);
      setup_in <= 16'h0ff0;
      tick(2);
      chk("pin_setup", 16'h1234, setup_out);
      wr(`WRR_ADDR_OPM_CTRL, 8'h00);
      tick(2);
      chk("pin_setup", 16'h0ff0, setup_out);
      pd(`WRR_PD_DEEP, 1'b1);
      chk("pin_flag", 16'h0000, {15'h0000, flag});
      pd(`WRR_PD_REG_RET, 1'b0);
      pd(`WRR_PD_MEM_OFF, 1'b0);
      wr(`WRR_ADDR_OPM_CTRL, 8'h01);
      tick(4);
      pd(`WRR_PD_MEM_OFF, 1'b1);
      pd(`WRR_PD_MEM_ON, 1'b1);
      pd(`WRR_PD_REG_RET, 1'b1);
      $display("test latch and watchdog done");
   endtask

   initial begin
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      t_regs();
      t_reason();
      t_wake();
      t_pins();
      t_latch_wdt();
      summarize();
   end
endmodule
